// [verilog/dpwm_pkg.sv]
package dpwm_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  ADDR_CTRL_MAIN = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_FAST = 8'h04;
  localparam logic [7:0]  ADDR_COUNT     = 8'h08;
  localparam logic [7:0]  ADDR_CYCLE     = 8'h0c;
  localparam logic [7:0]  ADDR_DUTY      = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_REQ   = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_PRIO  = 8'h1c;

  // ----------------------------------------------------------------------
  // Field positions of the main control register
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_RUN0  = 0;
  localparam int unsigned CTRL_CK0   = 1;
  localparam int unsigned CTRL_SRC0  = 3;
  localparam int unsigned CTRL_RUN1  = 4;
  localparam int unsigned CTRL_CK1   = 5;
  localparam int unsigned CTRL_SRC1  = 7;

  // ----------------------------------------------------------------------
  // Count clock selections, limits and interrupt vectors
  // ----------------------------------------------------------------------
  localparam logic [1:0]  CKS_CPU    = 2'h0;
  localparam logic [1:0]  CKS_TB2    = 2'h1;
  localparam logic [1:0]  CKS_TB4    = 2'h2;
  localparam logic [1:0]  CKS_EXT    = 2'h3;
  localparam logic [7:0]  CNT_MAX    = 8'hff;
  localparam logic [15:0] WIDE_MAX   = 16'hffff;
  localparam logic [15:0] VEC_CH0    = 16'h006a;
  localparam logic [15:0] VEC_CH1    = 16'h006c;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [6:0]  FAST_FILL  = 7'h7f;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic        fast;
    logic [7:0]  cnt0;
    logic [7:0]  cnt1;
    logic [7:0]  cyc0;
    logic [7:0]  cyc1;
    logic [7:0]  duty0;
    logic [7:0]  duty1;
    logic        ff0;
    logic        ff1;
    logic [1:0]  req;
    logic [1:0]  en;
    logic [3:0]  prio;
    logic [1:0]  tbdiv;
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } dpwm_state_s;

endpackage : dpwm_pkg

// [verilog/dpwm_top.sv]
// Contract
// - Output flip-flop rests high, so the pin is high before any start.
// - Setting a run bit starts counting and sets the output flip-flop.
// - 8-bit counter equal to duty raises request and drives output low.
// - 8-bit overflow sets output high and reloads counter from cycle value.
// - Clearing a run bit stops the channel and drives its output high.
// - Duty 00H gives one tick high; FFH gives constant high; zero impossible.
// - In cascaded mode only channel 1's pin carries the waveform.
// - 16-bit counter equal to duty raises channel 1 request, output low.
// - 16-bit overflow sets output high and reloads from 16-bit cycle value.
// - Channel 0 request still fires on low-byte match and low-byte overflow.
// - 16-bit duty 0000H gives one tick high; FFFFH gives constant high.
// - Fast mode bumps the low byte on each overflow of the upper byte.
// - Fast mode drives output high while counter is at most duty.
// - Fast mode gives up to 256 pulses per cycle, same resolution.
// - Normal 16-bit mode gives exactly one pulse per cycle.
// - First period after a start may be shortened by the count clock.
// - The selected interrupt factor of each channel sets its request flag.
// - Each request is maskable and carries a two-bit priority.
// - Each channel's overflow and match share one request flag and vector.
// - Two-bit clock select: CPU, base tick/2, base tick/4, or external.
// - Channel 1 select of 11 cascades channel 0 overflow into channel 1.
// - Per-channel select picks match (0) or overflow (1) as request source.
// - Writing a counter writes the same value into its cycle register.
`timescale 1ns/10ps
module dpwm_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        TB_TICK_I,
  input  wire logic        AUX_OVF_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic             PWM_OUT_CH0_O,
  output logic             PWM_OUT_CH1_O,
  output logic             IRQ_CH0_O,
  output logic             IRQ_CH1_O,
  output logic [1:0]       PRIO_CH0_O,
  output logic [1:0]       PRIO_CH1_O
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic reg_known(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    reg_known = (w == dpwm_pkg::ADDR_CTRL_MAIN) || (w == dpwm_pkg::ADDR_CTRL_FAST) ||
                (w == dpwm_pkg::ADDR_COUNT) || (w == dpwm_pkg::ADDR_CYCLE) ||
                (w == dpwm_pkg::ADDR_DUTY) || (w == dpwm_pkg::ADDR_IRQ_REQ) ||
                (w == dpwm_pkg::ADDR_IRQ_EN) || (w == dpwm_pkg::ADDR_IRQ_PRIO);
  endfunction : reg_known

  function automatic logic clk_pick(input logic [1:0] sel, input logic tb2,
                                    input logic tb4, input logic ext);
    unique case (sel)
      dpwm_pkg::CKS_CPU: clk_pick = 1'b1;
      dpwm_pkg::CKS_TB2: clk_pick = tb2;
      dpwm_pkg::CKS_TB4: clk_pick = tb4;
      dpwm_pkg::CKS_EXT: clk_pick = ext;
    endcase
  endfunction : clk_pick

  // Returns {overflow, match, flip-flop, counter} after one tick.
  function automatic logic [10:0] step8(input logic [7:0] cnt, input logic [7:0] cyc,
                                        input logic [7:0] duty, input logic ff);
    logic ovf;
    logic mat;
    logic [7:0] nc;
    logic nf;
    ovf = (cnt == dpwm_pkg::CNT_MAX);
    mat = (cnt == duty);
    nc  = ovf ? cyc : 8'(cnt + 8'h01);
    // Overflow outranks match, so duty FFH stays high all period.
    nf  = ovf ? 1'b1 : (mat ? 1'b0 : ff);
    step8 = {ovf, mat, nf, nc};
  endfunction : step8

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dpwm_pkg::dpwm_state_s r_reg;
  dpwm_pkg::dpwm_state_s r_next;

  logic        tb2;
  logic        tb4;
  logic        tick0;
  logic        tick1;
  logic        cascade;
  logic        fast_on;
  logic        wide_run;
  logic        wr_do;
  logic [10:0] s0;
  logic [10:0] s1;

  assign S_AXI_AWREADY_O = !r_reg.aw_ok && !r_reg.bvalid;
  assign S_AXI_WREADY_O  = !r_reg.w_ok && !r_reg.bvalid;
  assign S_AXI_BVALID_O  = r_reg.bvalid;
  assign S_AXI_BRESP_O   = r_reg.bresp;
  assign S_AXI_ARREADY_O = !r_reg.rvalid;
  assign S_AXI_RVALID_O  = r_reg.rvalid;
  assign S_AXI_RDATA_O   = r_reg.rdata;
  assign S_AXI_RRESP_O   = r_reg.rresp;
  assign PWM_OUT_CH0_O   = r_reg.ff0;
  assign PWM_OUT_CH1_O   = r_reg.ff1;
  assign IRQ_CH0_O       = r_reg.req[0] & r_reg.en[0];
  assign IRQ_CH1_O       = r_reg.req[1] & r_reg.en[1];
  assign PRIO_CH0_O      = r_reg.prio[1:0];
  assign PRIO_CH1_O      = r_reg.prio[3:2];

  assign cascade  = &r_reg.ctrl[dpwm_pkg::CTRL_CK1 +: 2];
  assign fast_on  = r_reg.fast & cascade;
  assign wide_run = fast_on ? r_reg.ctrl[dpwm_pkg::CTRL_RUN1]
                            : (r_reg.ctrl[dpwm_pkg::CTRL_RUN0] & r_reg.ctrl[dpwm_pkg::CTRL_RUN1]);
  assign wr_do    = r_reg.aw_ok && r_reg.w_ok;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] wide;
    logic [15:0] wduty;
    logic        lo_ovf;
    logic        lo_mat;
    logic        w_ovf;
    logic        w_mat;
    logic        hi_ovf;
    logic [1:0]  ev;
    logic [1:0]  clr;
    logic [7:0]  old_ctrl;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [31:0] rd;
    wide   = {r_reg.cnt1, r_reg.cnt0};
    wduty  = {r_reg.duty1, r_reg.duty0};
    lo_ovf = 1'b0;
    lo_mat = 1'b0;
    w_ovf  = 1'b0;
    w_mat  = 1'b0;
    hi_ovf = 1'b0;
    ev     = 2'h0;
    clr    = 2'h0;
    old_ctrl = r_reg.ctrl;
    wa     = {r_reg.aw_addr[7:2], 2'h0};
    wd     = r_reg.w_data;
    rd     = 32'h0000_0000;
    r_next = r_reg;

    r_next.tbdiv = 2'(r_reg.tbdiv + {1'b0, TB_TICK_I});
    tb2   = TB_TICK_I & r_reg.tbdiv[0];
    tb4   = TB_TICK_I & (&r_reg.tbdiv);
    tick0 = clk_pick(r_reg.ctrl[dpwm_pkg::CTRL_CK0 +: 2], tb2, tb4, AUX_OVF_I);
    tick1 = clk_pick(r_reg.ctrl[dpwm_pkg::CTRL_CK1 +: 2], tb2, tb4, 1'b0);
    s0 = step8(r_reg.cnt0, r_reg.cyc0, r_reg.duty0, r_reg.ff0);
    s1 = step8(r_reg.cnt1, r_reg.cyc1, r_reg.duty1, r_reg.ff1);

    if (cascade) begin
      r_next.ff0 = 1'b1;
      if (wide_run && tick0) begin
        lo_mat = (r_reg.cnt0 == r_reg.duty0);
        w_mat  = (wide == wduty);
        if (fast_on) begin
          hi_ovf = (r_reg.cnt1 == dpwm_pkg::CNT_MAX);
          w_ovf  = hi_ovf && (r_reg.cnt0 == dpwm_pkg::CNT_MAX);
          lo_ovf = w_ovf;
          r_next.cnt1 = 8'(r_reg.cnt1 + 8'h01);
          if (hi_ovf) begin
            r_next.cnt0 = 8'(r_reg.cnt0 + 8'h01);
          end
          if (w_ovf) begin
            r_next.cnt0 = r_reg.cyc0;
            r_next.cnt1 = r_reg.cyc1;
          end
        end else begin
          w_ovf  = (wide == dpwm_pkg::WIDE_MAX);
          lo_ovf = (r_reg.cnt0 == dpwm_pkg::CNT_MAX);
          {r_next.cnt1, r_next.cnt0} = w_ovf ? {r_reg.cyc1, r_reg.cyc0}
                                             : 16'(wide + 16'h0001);
          r_next.ff1 = w_ovf ? 1'b1 : (w_mat ? 1'b0 : r_reg.ff1);
        end
        ev[0] = r_reg.ctrl[dpwm_pkg::CTRL_SRC0] ? lo_ovf : lo_mat;
        ev[1] = r_reg.ctrl[dpwm_pkg::CTRL_SRC1] ? w_ovf : w_mat;
      end
    end else begin
      if (r_reg.ctrl[dpwm_pkg::CTRL_RUN0] && tick0) begin
        {r_next.ff0, r_next.cnt0} = s0[8:0];
        ev[0] = r_reg.ctrl[dpwm_pkg::CTRL_SRC0] ? s0[10] : s0[9];
      end
      if (r_reg.ctrl[dpwm_pkg::CTRL_RUN1] && tick1) begin
        {r_next.ff1, r_next.cnt1} = s1[8:0];
        ev[1] = r_reg.ctrl[dpwm_pkg::CTRL_SRC1] ? s1[10] : s1[9];
      end
    end

    // ---------------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------------
    r_next.bvalid = r_reg.bvalid && !S_AXI_BREADY_I;
    if (wr_do) begin
      r_next.aw_ok  = 1'b0;
      r_next.w_ok   = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = reg_known(r_reg.aw_addr) ? dpwm_pkg::RESP_OKAY : dpwm_pkg::RESP_SLVERR;
      if (r_reg.w_strb[0]) begin
        unique case (wa)
          dpwm_pkg::ADDR_CTRL_MAIN: r_next.ctrl = wd[7:0];
          dpwm_pkg::ADDR_CTRL_FAST: r_next.fast = wd[0];
          dpwm_pkg::ADDR_COUNT: begin
            r_next.cnt0 = wd[7:0];
            r_next.cyc0 = wd[7:0];
          end
          dpwm_pkg::ADDR_CYCLE:     r_next.cyc0  = wd[7:0];
          dpwm_pkg::ADDR_DUTY:      r_next.duty0 = wd[7:0];
          dpwm_pkg::ADDR_IRQ_REQ:   clr = wd[1:0];
          dpwm_pkg::ADDR_IRQ_EN:    r_next.en = wd[1:0];
          dpwm_pkg::ADDR_IRQ_PRIO:  r_next.prio = wd[3:0];
          default: ;
        endcase
      end
      if (r_reg.w_strb[1]) begin
        unique case (wa)
          dpwm_pkg::ADDR_COUNT: begin
            r_next.cnt1 = wd[15:8];
            r_next.cyc1 = wd[15:8];
          end
          dpwm_pkg::ADDR_CYCLE: r_next.cyc1  = wd[15:8];
          dpwm_pkg::ADDR_DUTY:  r_next.duty1 = wd[15:8];
          default: ;
        endcase
      end
    end
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      r_next.aw_ok   = 1'b1;
      r_next.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      r_next.w_ok   = 1'b1;
      r_next.w_data = S_AXI_WDATA_I;
      r_next.w_strb = S_AXI_WSTRB_I;
    end

    r_next.req = (r_reg.req & ~clr) | ev;

    if (r_next.ctrl[dpwm_pkg::CTRL_RUN0] && !old_ctrl[dpwm_pkg::CTRL_RUN0]) begin
      r_next.ff0 = 1'b1;
      r_next.ff1 = cascade ? 1'b1 : r_next.ff1;
    end
    if (r_next.ctrl[dpwm_pkg::CTRL_RUN1] && !old_ctrl[dpwm_pkg::CTRL_RUN1]) begin
      r_next.ff1 = 1'b1;
    end

    if (!r_next.ctrl[dpwm_pkg::CTRL_RUN0]) begin
      r_next.ff0 = 1'b1;
    end
    if (&r_next.ctrl[dpwm_pkg::CTRL_CK1 +: 2]) begin
      r_next.ff0 = 1'b1;
      if (r_next.fast) begin
        if (!r_next.ctrl[dpwm_pkg::CTRL_RUN1]) begin
          r_next.ff1 = 1'b1;
        end else begin
          r_next.ff1 = ({r_next.cnt1, r_next.cnt0} <= {r_next.duty1, r_next.duty0});
        end
      end else if (!(r_next.ctrl[dpwm_pkg::CTRL_RUN0] && r_next.ctrl[dpwm_pkg::CTRL_RUN1])) begin
        r_next.ff1 = 1'b1;
      end
    end else if (!r_next.ctrl[dpwm_pkg::CTRL_RUN1]) begin
      r_next.ff1 = 1'b1;
    end

    // ---------------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------------
    unique case ({S_AXI_ARADDR_I[7:2], 2'h0})
      dpwm_pkg::ADDR_CTRL_MAIN: rd = {24'h00_0000, r_reg.ctrl};
      dpwm_pkg::ADDR_CTRL_FAST: rd = {24'h00_0000, dpwm_pkg::FAST_FILL, r_reg.fast};
      dpwm_pkg::ADDR_COUNT:     rd = {16'h0000, r_reg.cnt1, r_reg.cnt0};
      dpwm_pkg::ADDR_CYCLE:     rd = {16'h0000, r_reg.cyc1, r_reg.cyc0};
      dpwm_pkg::ADDR_DUTY:      rd = {16'h0000, r_reg.duty1, r_reg.duty0};
      dpwm_pkg::ADDR_IRQ_REQ:   rd = {30'h0000_0000, r_reg.req};
      dpwm_pkg::ADDR_IRQ_EN:    rd = {30'h0000_0000, r_reg.en};
      dpwm_pkg::ADDR_IRQ_PRIO:  rd = {28'h000_0000, r_reg.prio};
      default:                  rd = 32'h0000_0000;
    endcase
    r_next.rvalid = r_reg.rvalid && !S_AXI_RREADY_I;
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = rd;
      r_next.rresp  = reg_known(S_AXI_ARADDR_I) ? dpwm_pkg::RESP_OKAY : dpwm_pkg::RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // The clock enable also freezes the bus slave, but its ready outputs stay up, so a handshake taken while it is low is lost.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_reg       <= '0;
      r_reg.ctrl  <= dpwm_pkg::RST_CTRL;
      r_reg.cnt0  <= dpwm_pkg::RST_BYTE;
      r_reg.ff0   <= 1'b1;
      r_reg.ff1   <= 1'b1;
    end else if (CE_I) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_START_HIGH: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(r_reg.ctrl[dpwm_pkg::CTRL_RUN0]) && !cascade |-> r_reg.ff0)
    else $error("Output not high after start.");

  AST_STOP_HIGH: assert property (@(posedge CLK_I) disable iff (RST_I)
    !r_reg.ctrl[dpwm_pkg::CTRL_RUN0] |-> PWM_OUT_CH0_O)
    else $error("Stopped channel 0 output not high.");

  AST_OVF_RELOAD: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && !cascade && tick0 && r_reg.ctrl[dpwm_pkg::CTRL_RUN0] && !wr_do &&
    r_reg.cnt0 == dpwm_pkg::CNT_MAX |=> r_reg.cnt0 == $past(r_reg.cyc0) && r_reg.ff0)
    else $error("Overflow did not reload and set output.");

  AST_MATCH_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && !cascade && tick0 && r_reg.ctrl[dpwm_pkg::CTRL_RUN0] && !wr_do &&
    r_reg.cnt0 == r_reg.duty0 && r_reg.cnt0 != dpwm_pkg::CNT_MAX |=> !PWM_OUT_CH0_O)
    else $error("Match did not drive output low.");

  AST_REQ_SET: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && !cascade && tick0 && r_reg.ctrl[dpwm_pkg::CTRL_RUN0] &&
    !r_reg.ctrl[dpwm_pkg::CTRL_SRC0] && r_reg.cnt0 == r_reg.duty0 |=> r_reg.req[0])
    else $error("Match did not set channel 0 request.");

  AST_MASK: assert property (@(posedge CLK_I) disable iff (RST_I)
    !r_reg.en[1] |-> !IRQ_CH1_O ##1 (r_reg.en[1] || !IRQ_CH1_O))
    else $error("Masked request reached the interrupt output.");

  AST_CASC_CH0: assert property (@(posedge CLK_I) disable iff (RST_I)
    cascade && $past(cascade) |-> PWM_OUT_CH0_O)
    else $error("Channel 0 pin active in cascaded mode.");

  AST_FAST_CMP: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && r_next.fast && (&r_next.ctrl[dpwm_pkg::CTRL_CK1 +: 2]) &&
    r_next.ctrl[dpwm_pkg::CTRL_RUN1] |=>
    r_reg.ff1 == ({r_reg.cnt1, r_reg.cnt0} <= {r_reg.duty1, r_reg.duty0}))
    else $error("Fast mode output disagrees with compare.");

  AST_CNT_CYC: assert property (@(posedge CLK_I) disable iff (RST_I)
    CE_I && wr_do && r_reg.w_strb[0] && {r_reg.aw_addr[7:2], 2'h0} == dpwm_pkg::ADDR_COUNT
    |=> r_reg.cyc0 == r_reg.cnt0 && r_reg.cyc0 == $past(r_reg.w_data[7:0]))
    else $error("Counter write did not update cycle value.");

  AST_BHOLD: assert property (@(posedge CLK_I) disable iff (RST_I)
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("Write response dropped before taken.");

endmodule : dpwm_top

// [testbench/dpwm_load.sv]
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Pin load that tallies high samples and rising edges
// ---------------------------------------------------------------
module dpwm_load (
  input  wire logic   clk_i,
  input  wire logic   pin_i,
  input  wire logic   clear_i,
  output logic [31:0] hi_o,
  output logic [31:0] rise_o
);
  logic prev_reg;
  // A passive load only listens, so tallies are all it can offer.
  always_ff @(posedge clk_i) begin
    prev_reg <= pin_i;
    if (clear_i) begin
      hi_o   <= 32'h0;
      rise_o <= 32'h0;
    end else begin
      hi_o   <= hi_o + {31'h0, pin_i};
      rise_o <= rise_o + {31'h0, pin_i & ~prev_reg};
    end
  end
endmodule : dpwm_load

// [testbench/test_dpwm_top.sv]
`timescale 1ns/10ps
module test_dpwm_top;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, clr, tbt;
  logic [7:0]  awaddr, araddr, c, d;
  logic [31:0] wdata, rd, hi0, hi1, ri0, ri1, seed;
  logic [1:0]  bresp, rresp, rr, s, prio0, prio1;
  logic        awready, wready, bvalid, arready, rvalid, pwm0, pwm1, irq0, irq1;
  logic [31:0] rdata;
  int          fail_count, n_compared, i, m;
  // ---------------------------------------------------------------
  // Clock, design and loads
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A base tick on every other cycle shows the dividers really count ticks, not clocks.
  always @(posedge clk) tbt <= rst ? 1'b0 : ~tbt;
  dpwm_top u_dpwm_top (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .TB_TICK_I(tbt),
    .AUX_OVF_I(tbt), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .PWM_OUT_CH0_O(pwm0), .PWM_OUT_CH1_O(pwm1), .IRQ_CH0_O(irq0), .IRQ_CH1_O(irq1),
    .PRIO_CH0_O(prio0), .PRIO_CH1_O(prio1));
  dpwm_load u_dpwm_load0 (.clk_i(clk), .pin_i(pwm0), .clear_i(clr), .hi_o(hi0), .rise_o(ri0));
  dpwm_load u_dpwm_load1 (.clk_i(clk), .pin_i(pwm1), .clear_i(clr), .hi_o(hi1), .rise_o(ri1));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  function automatic int f_mul(input logic [1:0] sel);
    return (sel == 2'h1) ? 4 : (sel == 2'h2) ? 8 : (sel == 2'h3) ? 2 : 1;
  endfunction : f_mul
  function automatic logic [31:0] f_hi(input logic [7:0] cy, dt, input int k);
    return 2 * k * ({24'h0, dt} - {24'h0, cy} + 32'h1);
  endfunction : f_hi
  task automatic chk_num(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_num
  task automatic chk_bit(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      aw_t = awready;
      w_t  = wready;
      b_t  = bvalid;
      rr   = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
    @(posedge clk);
    chk_num({30'h0, rr}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, rv_t;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ar_t = arready;
      rv_t = rvalid;
      rd   = rdata;
      rr   = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end while (!rv_t);
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd
  // Settle first so a shortened opening period never lands in the window.
  task automatic measure(input int settle, n);
    repeat (settle) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : measure
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, clr} = 7'h40;
    {awaddr, araddr, wdata} = 48'h0;
    fail_count = 0;
    n_compared = 0;
    seed = 32'he125ddba;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_bit(pwm0, 1'b1);
    chk_bit(pwm1, 1'b1);
    axi_rd(dpwm_pkg::ADDR_CTRL_FAST);
    chk_num(rd, 32'hfe);
    axi_rd(8'h20);
    chk_num({rd[29:0], rr}, {30'h0, dpwm_pkg::RESP_SLVERR});
    axi_wr(8'h24, 32'h5, dpwm_pkg::RESP_SLVERR);
    axi_wr(dpwm_pkg::ADDR_IRQ_EN, 32'h3, dpwm_pkg::RESP_OKAY);
    $display("reset and map test done");
    for (i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      s = i[1:0];
      c = (i < 2) ? 8'h0 : {1'b0, seed[6:0]};
      d = (i == 0) ? 8'h0 : (i == 1) ? 8'hff : c | seed[15:8];
      m = f_mul(s);
      axi_wr(dpwm_pkg::ADDR_CTRL_MAIN, 32'h0, dpwm_pkg::RESP_OKAY);
      chk_bit(pwm0, 1'b1);
      axi_wr(dpwm_pkg::ADDR_COUNT, {16'h0, c, c}, dpwm_pkg::RESP_OKAY);
      axi_wr(dpwm_pkg::ADDR_DUTY, {16'h0, d, d}, dpwm_pkg::RESP_OKAY);
      axi_rd(dpwm_pkg::ADDR_CYCLE);
      chk_num(rd, {16'h0, c, c});
      axi_wr(dpwm_pkg::ADDR_IRQ_REQ, 32'h3, dpwm_pkg::RESP_OKAY);
      axi_wr(dpwm_pkg::ADDR_CTRL_MAIN, {24'h0, 1'b0, 2'h0, 1'b1, 1'b0, s, 1'b1},
             dpwm_pkg::RESP_OKAY);
      measure((256 - c) * m, 2 * (256 - c) * m);
      chk_num(hi0, f_hi(c, d, m));
      chk_num(ri0, (d == 8'hff) ? 32'h0 : 32'h2);
      chk_num(hi1, f_hi(c, d, m));
      chk_bit(irq0, 1'b1);
      @(posedge clk);
      $display("eight-bit test %0d done", i);
    end
    axi_wr(dpwm_pkg::ADDR_IRQ_PRIO, 32'h9, dpwm_pkg::RESP_OKAY);
    chk_num({28'h0, prio1, prio0}, 32'h9);
    axi_wr(dpwm_pkg::ADDR_IRQ_EN, 32'h0, dpwm_pkg::RESP_OKAY);
    chk_bit(irq0, 1'b0);
    axi_wr(dpwm_pkg::ADDR_CTRL_MAIN, 32'h0, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_COUNT, 32'hfff0, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_DUTY, 32'hfff8, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_IRQ_REQ, 32'h3, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_IRQ_EN, 32'h3, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_CTRL_MAIN, 32'h78, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_CTRL_MAIN, 32'h79, dpwm_pkg::RESP_OKAY);
    measure(32, 4096);
    chk_num(hi1, 32'd2304);
    chk_num(ri1, 32'd256);
    chk_num(hi0, 32'd4096);
    chk_bit(irq0, 1'b1);
    chk_bit(irq1, 1'b1);
    @(posedge clk);
    $display("cascade test done");
    axi_wr(dpwm_pkg::ADDR_CTRL_FAST, 32'h1, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_COUNT, 32'h00f0, dpwm_pkg::RESP_OKAY);
    axi_wr(dpwm_pkg::ADDR_DUTY, 32'h8080, dpwm_pkg::RESP_OKAY);
    measure(4096, 4096);
    chk_num(ri1, 32'd16);
    chk_num(hi1, 32'd2048);
    chk_num(hi0, 32'd4096);
    @(posedge clk);
    $display("fast mode test done");
    wrap_up();
  end
endmodule : test_dpwm_top
